// ===== rtl/ads_diag_top.sv
// Diagnostic status readback and instruction sequencing over a
// two-wire serial bus, device side.
// Assumes an external pull-up on SDA and a host that makes SCL.
`timescale 1ns/1ps
`include "ads_cfg.svh"

module ads_diag_top #(
    parameter int unsigned MEAS_CYCLES = `ADS_MEAS_TIME_US * `ADS_CLK_MHZ
) (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe,
    input  wire logic                     thermal_warn,
    input  ads_pkg::ads_fault_t [3:0]     fault_in,
    output logic [7:0]                    instruction_byte_one,
    output logic [7:0]                    instruction_byte_two
);

    // ********************************************************************
    // Parameter check and local constants
    // ********************************************************************

    // The window counter must hold the last count of the window.
    if (MEAS_CYCLES < 1 || MEAS_CYCLES >= (1 << `ADS_MEAS_W)) begin : g_chk
        $error("MEAS_CYCLES out of range for the window counter.");
    end

    localparam logic [`ADS_MEAS_W-1:0] MEAS_LAST =
        `ADS_MEAS_W'(MEAS_CYCLES - 1);

    ads_pkg::ads_regs_t  r_r;
    ads_pkg::ads_regs_t  r_nxt;
    ads_pkg::ads_pins_t  pins;
    ads_pkg::ads_pins_t  sy;
    ads_pkg::ads_fault_t lch;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_c;
    logic                stop_c;
    logic                load;
    logic                active;
    logic                meas_end;
    logic [1:0]          lidx;
    logic [2:0]          lb_hi;
    logic [4:0]          lb_lo;
    logic [7:0]          lb;

    // ********************************************************************
    // Input synchronisation
    // ********************************************************************

    assign pins.scl     = scl_in;
    assign pins.sda     = sda_in;
    assign pins.thermal = thermal_warn;
    assign pins.fault   = fault_in;

    ads_sync #(
        .WIDTH ($bits(ads_pkg::ads_pins_t))
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (pins),
        .q      (sy)
    );

    // Bus events from the filtered levels and their previous values.
    assign scl_rise = sy.scl && !r_r.scl_d;
    assign scl_fall = !sy.scl && r_r.scl_d;
    assign start_c  = sy.scl && r_r.scl_d && r_r.sda_d && !sy.sda;
    assign stop_c   = sy.scl && r_r.scl_d && !r_r.sda_d && sy.sda;

    // ********************************************************************
    // Status byte assembly
    // ********************************************************************

    // A byte is loaded after the address acknowledge or an acknowledged
    // data byte; the fourth byte is the last one offered.
    assign load = scl_fall &&
        ((r_r.st == ads_pkg::BUS_ACK && r_r.rw) ||
         (r_r.st == ads_pkg::BUS_RD_ACK && !r_r.nack &&
          r_r.idx != `ADS_LAST_BYTE));
    assign lidx = (r_r.st == ads_pkg::BUS_ACK) ? `ADS_SB_LF :
                  2'(r_r.idx + 2'd1);
    assign lch  = r_r.res[lidx];

    // Open load is not recognised in permanent diagnostics.
    assign lb_lo = {r_r.perm,
                    lch.short_load,
                    r_r.offs ? lch.offset :
                               (lch.open_load & ~r_r.perm),
                    lch.short_vcc,
                    lch.short_gnd};

    // Upper bits per byte; unused positions are forced low.
    assign lb_hi =
        (lidx == `ADS_SB_LF) ? {sy.thermal, r_r.done, 1'b0} :
        (lidx == `ADS_SB_LR) ? {r_r.ib1[`ADS_IB1_OFFS], 2'b00} :
        (lidx == `ADS_SB_RF) ? {r_r.ib2[`ADS_IB2_STBY],
                                r_r.ib1[`ADS_IB1_DIAG], 1'b0} :
        3'b000;
    assign lb = {lb_hi, lb_lo};

    // ********************************************************************
    // Bus engine and diagnostic window
    // ********************************************************************

    assign active   = r_r.ib1[`ADS_IB1_DIAG] || r_r.ib1[`ADS_IB1_OFFS];
    assign meas_end = active && !r_r.restart && r_r.meas == MEAS_LAST;

    // Next state of the whole block.
    always_comb begin
        r_nxt         = r_r;
        r_nxt.scl_d   = sy.scl;
        r_nxt.sda_d   = sy.sda;
        r_nxt.restart = 1'b0;
        if (start_c) begin
            r_nxt.st  = ads_pkg::BUS_ADDR;
            r_nxt.cnt = 4'd0;
            r_nxt.rw  = 1'b0;
        end else if (stop_c) begin
            r_nxt.st      = ads_pkg::BUS_IDLE;
            r_nxt.restart = r_r.rw;
        end else begin
            case (r_r.st)
                ads_pkg::BUS_ADDR, ads_pkg::BUS_WR: begin
                    if (scl_rise) begin
                        r_nxt.sh  = {r_r.sh[6:0], sy.sda};
                        r_nxt.cnt = r_r.cnt + 4'd1;
                    end else if (scl_fall && r_r.cnt == `ADS_BITS) begin
                        r_nxt.cnt = 4'd0;
                        if (r_r.st == ads_pkg::BUS_ADDR) begin
                            if (r_r.sh[7:1] == `ADS_DEV_ADDR) begin
                                r_nxt.st  = ads_pkg::BUS_ACK;
                                r_nxt.rw  = r_r.sh[0];
                                r_nxt.idx = `ADS_IDX_IB1;
                            end else begin
                                r_nxt.st = ads_pkg::BUS_IGNORE;
                            end
                        end else if (r_r.idx == `ADS_IDX_IB1) begin
                            r_nxt.ib1 = r_r.sh;
                            r_nxt.idx = `ADS_IDX_IB2;
                            r_nxt.st  = ads_pkg::BUS_ACK;
                        end else if (r_r.idx == `ADS_IDX_IB2) begin
                            r_nxt.ib2 = r_r.sh;
                            r_nxt.idx = 2'(r_r.idx + 2'd1);
                            r_nxt.st  = ads_pkg::BUS_ACK;
                        end else begin
                            r_nxt.st = ads_pkg::BUS_IGNORE;
                        end
                    end
                end
                ads_pkg::BUS_ACK: begin
                    if (load) begin
                        r_nxt.st  = ads_pkg::BUS_RD;
                        r_nxt.sh  = lb;
                        r_nxt.cnt = 4'd0;
                    end else if (scl_fall) begin
                        r_nxt.st = ads_pkg::BUS_WR;
                    end
                end
                ads_pkg::BUS_RD: begin
                    if (scl_fall) begin
                        if (r_r.cnt == `ADS_BITS - 4'd1) begin
                            r_nxt.st = ads_pkg::BUS_RD_ACK;
                        end else begin
                            r_nxt.sh  = {r_r.sh[6:0], 1'b0};
                            r_nxt.cnt = r_r.cnt + 4'd1;
                        end
                    end
                end
                ads_pkg::BUS_RD_ACK: begin
                    if (scl_rise) begin
                        r_nxt.nack = sy.sda;
                    end else if (load) begin
                        r_nxt.st  = ads_pkg::BUS_RD;
                        r_nxt.sh  = lb;
                        r_nxt.idx = lidx;
                        r_nxt.cnt = 4'd0;
                    end else if (scl_fall) begin
                        r_nxt.st = ads_pkg::BUS_IGNORE;
                    end
                end
                default: begin
                end
            endcase
        end

        // A read restarts the window, so a change needs two reads to show.
        if (!active || r_r.restart) begin
            r_nxt.meas = '0;
            r_nxt.acc  = '1;
            r_nxt.done = 1'b0;
        end else if (meas_end) begin
            r_nxt.res  = r_r.acc & sy.fault;
            r_nxt.perm = r_r.ib2[`ADS_IB2_STBY];
            r_nxt.offs = r_r.ib1[`ADS_IB1_OFFS];
            r_nxt.done = 1'b1;
            r_nxt.meas = '0;
            r_nxt.acc  = '1;
        end else begin
            r_nxt.meas = r_r.meas + 1'b1;
            r_nxt.acc  = r_r.acc & sy.fault;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Open-drain drive: low during acknowledge and for zero data bits.
    assign sda_out = 1'b0;
    assign sda_oe  = (r_r.st == ads_pkg::BUS_ACK) ||
                     (r_r.st == ads_pkg::BUS_RD && !r_r.sh[7]);
    assign instruction_byte_one = r_r.ib1;
    assign instruction_byte_two = r_r.ib2;

    // ********************************************************************
    // Assertions
    // ********************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    addr_match_a: assert property (scl_fall && !start_c && !stop_c &&
        r_r.st == ads_pkg::BUS_ADDR && r_r.cnt == `ADS_BITS &&
        r_r.sh[7:1] == `ADS_DEV_ADDR |=> r_r.st == ads_pkg::BUS_ACK &&
        r_r.rw == $past(r_r.sh[0]))
        else $error("Address match not acknowledged.");
    four_bytes_a: assert property (!start_c && !stop_c && scl_fall &&
        r_r.st == ads_pkg::BUS_RD_ACK && r_r.idx == `ADS_LAST_BYTE
        |=> r_r.st == ads_pkg::BUS_IGNORE && !sda_oe)
        else $error("More than four status bytes sent.");
    thermal_bit_a: assert property (load && lidx == `ADS_SB_LF
        |=> r_r.sh[7] == $past(sy.thermal) && r_r.sh[6] == $past(r_r.done))
        else $error("First byte high bits wrong.");
    restart_a: assert property (r_r.restart && active
        |=> r_r.meas == '0 && !r_r.done ##1 !r_r.done)
        else $error("Read did not restart the cycle.");
    chan_low_a: assert property (load |=> r_r.sh[4] == $past(r_r.perm) &&
        r_r.sh[3] == $past(lch.short_load) &&
        r_r.sh[1:0] == $past({lch.short_vcc, lch.short_gnd}))
        else $error("Channel fault bits wrong.");
    offset_bit_a: assert property (load && r_r.offs
        |=> r_r.sh[2] == $past(lch.offset))
        else $error("Offset flag not reported.");
    echo_bits_a: assert property (load && lidx == `ADS_SB_RF
        |=> r_r.sh[7:6] == $past({r_r.ib2[`ADS_IB2_STBY],
                                   r_r.ib1[`ADS_IB1_DIAG]}))
        else $error("Control echo wrong.");
    offs_en_a: assert property (load && lidx == `ADS_SB_LR
        |=> r_r.sh[7:5] == {$past(r_r.ib1[`ADS_IB1_OFFS]), 2'b00})
        else $error("Offset enable echo wrong.");
    unused_zero_a: assert property (load && lidx == `ADS_SB_RR
        |=> r_r.sh[7:5] == 3'b000)
        else $error("Unused status bits not zero.");
    persist_a: assert property (meas_end
        |=> (r_r.res & ~$past(r_r.acc)) == '0 && r_r.done)
        else $error("Transient fault reported.");

    read_c:   cover property (scl_fall && r_r.st == ads_pkg::BUS_RD_ACK &&
                              r_r.idx == `ADS_LAST_BYTE);
    write_c:  cover property (r_r.st == ads_pkg::BUS_WR &&
                              r_r.idx == `ADS_IDX_IB2 + 2'd1);
    window_c: cover property (meas_end);
    start_c1: cover property (start_c);

endmodule

// ===== rtl/ads_cfg.svh
// Constants of the diagnostic readback block: bus address, field
// positions, reset values and timing figures.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ADS_CFG_SVH
`define ADS_CFG_SVH

// Clock rate and measurement window.
`define ADS_CLK_MHZ      25
`define ADS_MEAS_TIME_US 1000
`define ADS_MEAS_W       24

// Serial bus framing.
`define ADS_DEV_ADDR     7'h6c
`define ADS_BITS         4'd8
`define ADS_LAST_BYTE    2'd3
`define ADS_IDX_IB1      2'd0
`define ADS_IDX_IB2      2'd1

// Instruction byte fields.
`define ADS_IB_RST       8'h00
`define ADS_IB1_DIAG     6
`define ADS_IB1_OFFS     5
`define ADS_IB2_STBY     4

// Status byte index of each channel.
`define ADS_SB_LF        2'd0
`define ADS_SB_LR        2'd1
`define ADS_SB_RF        2'd2
`define ADS_SB_RR        2'd3

`endif

// ===== rtl/ads_pkg.sv
// Types shared by the diagnostic readback block.
// Assumes ads_cfg.svh is on the include path.
`include "ads_cfg.svh"

package ads_pkg;

    // Serial bus engine states.
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_ACK, BUS_WR, BUS_RD, BUS_RD_ACK, BUS_IGNORE
    } ads_bus_t;

    // Fault flags of one output channel.
    typedef struct packed {
        logic short_load;
        logic open_load;
        logic offset;
        logic short_vcc;
        logic short_gnd;
    } ads_fault_t;

    // Inputs that arrive from outside the clock domain.
    typedef struct packed {
        logic                 scl;
        logic                 sda;
        logic                 thermal;
        ads_fault_t [3:0]     fault;
    } ads_pins_t;

    // Whole state of the top module.
    typedef struct packed {
        ads_bus_t             st;
        logic [3:0]           cnt;
        logic [7:0]           sh;
        logic [1:0]           idx;
        logic                 rw;
        logic                 nack;
        logic                 scl_d;
        logic                 sda_d;
        logic [7:0]           ib1;
        logic [7:0]           ib2;
        logic [`ADS_MEAS_W-1:0] meas;
        ads_fault_t [3:0]     acc;
        ads_fault_t [3:0]     res;
        logic                 perm;
        logic                 offs;
        logic                 done;
        logic                 restart;
    } ads_regs_t;

endpackage

// ===== rtl/ads_sync.sv
// Three-stage input synchroniser with an agreement filter on its last two stages.
// Assumes asynchronous inputs; output follows only when stages 2 and 3
// agree, so a single-cycle glitch never reaches the bus engine.
`timescale 1ns/1ps

module ads_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] hold;
    } ads_sync_t;

    ads_sync_t r_r;
    ads_sync_t r_nxt;

    // Agreement is taken without a further register to save latency on SCL.
    genvar g;
    for (g = 0; g < WIDTH; g++) begin : g_bit
        assign q[g] = (r_r.s2[g] == r_r.s3[g]) ? r_r.s3[g] : r_r.hold[g];
    end

    // Shift chain; the first stage feeds only the second.
    always_comb begin
        r_nxt      = r_r;
        r_nxt.s1   = d;
        r_nxt.s2   = r_r.s1;
        r_nxt.s3   = r_r.s2;
        r_nxt.hold = q;
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

endmodule

// ===== dv/ads_host_bfm.sv
// Host side of the two-wire bus: makes SCL and pulls SDA low when needed.
// Assumes SDA is resolved outside with a pull-up, and paces itself on clk.
`timescale 1ns/1ps

module ads_host_bfm (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // Extra cycles of SCL low; raising it models a slow host.
    int slow = 0;

    // Bus idle: SCL high and SDA released, so the pull-up holds it high.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Every change lands 1 ns after a clock edge, never on the edge itself.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One bit, 320 ns: SDA moves in the low phase, is sampled at the rise.
    task automatic bit_x(input logic b, output logic s);
        tick(2);
        sda_low = ~b;
        tick(3 + slow);
        scl = 1'b1;
        s = sda;
        tick(3);
        scl = 1'b0;
    endtask

    // SDA falls while SCL is high; the clock stands still outside frames.
    task automatic start();
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    // SDA rises while SCL is high, then the bus is left idle.
    task automatic stop();
        tick(2);
        sda_low = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask

    // Eight bits MSB first, then the acknowledge clock of every byte.
    task automatic xfer(input logic [7:0] d, input logic nine,
                        output logic [7:0] q, output logic ack_low);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
            q[i] = s;
        end
        bit_x(nine, s);
        ack_low = ~s;
    endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the diagnostic readback block.
// Assumes ads_cfg.svh on the include path and the host model beside it.
`timescale 1ns/1ps
`include "ads_cfg.svh"

`define CHK(nm, ex, gt) \
    begin \
        checks++; \
        if ((gt) !== (ex)) begin \
            fail_count++; \
            $display("FAIL %s expected %h got %h", nm, ex, gt); \
        end \
    end

module testbench;
    // A short window keeps the run small yet longer than one whole read.
    localparam int unsigned MEAS   = 400;
    localparam logic [7:0]  ADR_WR = {`ADS_DEV_ADDR, 1'b0};
    localparam logic [7:0]  ADR_RD = {`ADS_DEV_ADDR, 1'b1};

    logic                      clk = 1'b0;
    logic                      resetn = 1'b0;
    logic                      scl;
    logic                      host_low;
    logic                      sda;
    logic                      sda_oe;
    logic                      sda_zero;
    logic                      thermal_warn = 1'b0;
    ads_pkg::ads_fault_t [3:0] fault_in = '0;
    logic [7:0]                ib_one;
    logic [7:0]                ib_two;
    logic [3:0][7:0]           st;
    int                        fail_count = 0;
    int                        checks = 0;

    // Open-drain wire with pull-up: low if either party pulls it.
    assign sda = ~(sda_oe | host_low);

    always #20 clk = ~clk;

    ads_diag_top #(.MEAS_CYCLES(MEAS)) u_ads_diag_top (
        .clk                  (clk),
        .resetn               (resetn),
        .scl_in               (scl),
        .sda_in               (sda),
        .sda_out              (sda_zero),
        .sda_oe               (sda_oe),
        .thermal_warn         (thermal_warn),
        .fault_in             (fault_in),
        .instruction_byte_one (ib_one),
        .instruction_byte_two (ib_two)
    );

    ads_host_bfm u_ads_host_bfm (
        .clk     (clk),
        .sda     (sda),
        .scl     (scl),
        .sda_low (host_low)
    );

    //**********************************************************************
    // Shared bus tasks and the expected status bytes
    //**********************************************************************

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Both instruction bytes, each acknowledged, then the outputs hold them.
    task automatic wr_ib(input logic [7:0] b1, input logic [7:0] b2);
        logic [7:0] q;
        logic       a;
        u_ads_host_bfm.start();
        u_ads_host_bfm.xfer(ADR_WR, 1'b1, q, a);
        `CHK("write address ack", 1'b1, a)
        u_ads_host_bfm.xfer(b1, 1'b1, q, a);
        `CHK("first byte ack", 1'b1, a)
        u_ads_host_bfm.xfer(b2, 1'b1, q, a);
        `CHK("second byte ack", 1'b1, a)
        u_ads_host_bfm.stop();
        `CHK("instruction one", b1, ib_one)
        `CHK("instruction two", b2, ib_two)
    endtask

    // Four status bytes, each with a host acknowledge clock, then stop.
    task automatic rd_st();
        logic [7:0] q;
        logic       a;
        u_ads_host_bfm.start();
        u_ads_host_bfm.xfer(ADR_RD, 1'b1, q, a);
        `CHK("read address ack", 1'b1, a)
        for (int i = 0; i < 4; i++) begin
            u_ads_host_bfm.xfer(8'hff, 1'b0, st[i], a);
        end
        u_ads_host_bfm.stop();
    endtask

    // Unused bits are zero; open load is hidden in permanent mode.
    function automatic logic [3:0][7:0] exp_st(input logic th,
        input logic dn, input logic [7:0] i1, input logic [7:0] i2,
        input ads_pkg::ads_fault_t [3:0] f);
        logic [3:0][7:0] e;
        for (int i = 0; i < 4; i++) begin
            e[i] = {3'h0, i2[4], f[i].short_load,
                    i1[5] ? f[i].offset : (f[i].open_load & ~i2[4]),
                    f[i].short_vcc, f[i].short_gnd};
        end
        e[0][7:6] = {th, dn};
        e[1][7] = i1[5];
        e[2][7:6] = {i2[4], i1[6]};
        return e;
    endfunction

    task automatic cmp_st(input logic [3:0][7:0] e, input logic [3:0][7:0] m);
        for (int i = 0; i < 4; i++) begin
            `CHK("status byte", e[i] & m[i], st[i] & m[i])
        end
    endtask

    //**********************************************************************
    // Scenarios
    //**********************************************************************

    // Reset clears the instruction bytes and releases SDA.
    task automatic sc_reset();
        resetn = 1'b0;
        step(2);
        `CHK("reset ib one", 8'h00, ib_one)
        `CHK("reset ib two", 8'h00, ib_two)
        `CHK("reset sda oe", 1'b0, sda_oe)
        `CHK("sda out", 1'b0, sda_zero)
        resetn = 1'b1;
        step(4);
    endtask

    // Power-up, diagnostics, offset and power-off patterns and their echoes.
    task automatic sc_table();
        logic [3:0][15:0] pat;
        pat = {16'h0000, 16'h2610, 16'h4010, 16'h0013};
        for (int i = 0; i < 4; i++) begin
            wr_ib(pat[i][15:8], pat[i][7:0]);
            rd_st();
            cmp_st(exp_st(1'b0, 1'b0, pat[i][15:8], pat[i][7:0], '0),
                   {8'he0, 8'he0, 8'he0, 8'ha0});
        end
    endtask

    // Turn-on faults show only after a whole window and lag one read.
    task automatic sc_fault();
        logic [3:0][7:0] full;
        full = '1;
        wr_ib(8'h40, 8'h00);
        fault_in = {5'h10, 5'h08, 5'h02, 5'h01};
        thermal_warn = 1'b1;
        rd_st();
        step(MEAS + 40);
        fault_in = '0;
        rd_st();
        cmp_st(exp_st(1'b1, 1'b1, 8'h40, 8'h00,
               {5'h10, 5'h08, 5'h02, 5'h01}), full);
        thermal_warn = 1'b0;
        rd_st();
        // The window that closed during the last read saw the fault only at its start.
        cmp_st(exp_st(1'b0, 1'b0, 8'h40, 8'h00, '0),
               full);
        step(MEAS + 40);
        rd_st();
        cmp_st(exp_st(1'b0, 1'b1, 8'h40, 8'h00, '0), full);
        step(100);
        fault_in = {5'h01, 5'h02, 5'h10, 5'h08};
        // The read must land after the part-faulted window and before the
        // next one closes, so every byte shows that window.
        step(MEAS - 100);
        rd_st();
        cmp_st(exp_st(1'b0, 1'b1, 8'h40, 8'h00, '0), full);
        fault_in = '0;
    endtask

    // Permanent mode sets bit 4 and never reports an open load.
    task automatic sc_perm();
        wr_ib(8'h40, 8'h10);
        fault_in = {5'h09, 5'h0b, 5'h09, 5'h0a};
        rd_st();
        step(MEAS + 40);
        rd_st();
        cmp_st(exp_st(1'b0, 1'b1, 8'h40, 8'h10,
               {5'h09, 5'h0b, 5'h09, 5'h0a}), '1);
        fault_in = '0;
    endtask

    // Offset run: bit 2 carries the offset flag instead of open load.
    task automatic sc_offset();
        wr_ib(8'h26, 8'h10);
        fault_in = {5'h0c, 5'h08, 5'h0c, 5'h08};
        rd_st();
        step(MEAS + 40);
        rd_st();
        cmp_st(exp_st(1'b0, 1'b1, 8'h26, 8'h10,
               {5'h0c, 5'h08, 5'h0c, 5'h08}), '1);
        fault_in = '0;
    endtask

    // A foreign address and a third write byte are refused; slow host.
    task automatic sc_refuse();
        logic [7:0] q;
        logic       a;
        u_ads_host_bfm.slow = 4;
        u_ads_host_bfm.start();
        u_ads_host_bfm.xfer(ADR_WR ^ 8'h02, 1'b1, q, a);
        `CHK("foreign address ack", 1'b0, a)
        u_ads_host_bfm.xfer(8'h55, 1'b1, q, a);
        u_ads_host_bfm.stop();
        `CHK("ib one kept", 8'h26, ib_one)
        u_ads_host_bfm.start();
        u_ads_host_bfm.xfer(ADR_WR, 1'b1, q, a);
        u_ads_host_bfm.xfer(8'h40, 1'b1, q, a);
        u_ads_host_bfm.xfer(8'h10, 1'b1, q, a);
        u_ads_host_bfm.xfer(8'h55, 1'b1, q, a);
        `CHK("third byte ack", 1'b0, a)
        u_ads_host_bfm.stop();
        `CHK("ib one", 8'h40, ib_one)
        `CHK("ib two", 8'h10, ib_two)
        // A host refusal after the first status byte releases the line.
        u_ads_host_bfm.start();
        u_ads_host_bfm.xfer(ADR_RD, 1'b1, q, a);
        u_ads_host_bfm.xfer(8'hff, 1'b1, q, a);
        u_ads_host_bfm.xfer(8'hff, 1'b0, q, a);
        `CHK("after host nack", 8'hff, q)
        u_ads_host_bfm.stop();
        u_ads_host_bfm.slow = 0;
    endtask

    //**********************************************************************
    // Run control
    //**********************************************************************

    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence, ending with a reset in mid-run.
    initial begin
        sc_reset();
        sc_table();
        sc_fault();
        sc_perm();
        sc_offset();
        sc_refuse();
        sc_reset();
        final_report();
    end

    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        $display("FAIL run length expected end got timeout");
        final_report();
    end
endmodule
